// ==== src/interrupt_flag_enable_priority_bank.sv ====
// interrupt flag, enable and priority bank with proximity timer, on apb
// assumes sources pulse or hold srcReq synchronous to ref_clk,
// and the core samples the registered request outputs
//
// Summary of operation
// - reload value loads proximity timer on trigger
// - flag reads 1 after request, software writable
// - enable bit 1 permits, 0 blocks source
// - zero priority field disables the source
// - nonzero priority gives level 1 to 7
// - subpriority 0..3 orders equal priority sources
// - fourth slot: priority 28:26, subpriority 25:24
// - third slot: priority 20:18, subpriority 17:16
// - second slot priority sits at 12:10
// - bits 31:29, 23:21, 15:13 read zero
// - all implemented bits clear after reset
// - second sub 9:8, first 4:2 and 1:0
// - trigger level zero off, else at-or-below starts
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module interrupt_flag_enable_priority_bank
(
	input wire logic ref_clk, // system clock, 125 MHz
	input wire logic resetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, 1 = write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic [intc_pkg::NUM_SRC-1:0] srcReq, // source requests
	output logic reqValid, // a request is presented to the core
	output logic [intc_pkg::SRC_W-1:0] reqSource, // presented source index
	output intc_pkg::prio_t reqPriority, // presented priority level
	output intc_pkg::sub_t reqSubpriority, // presented subpriority
	output logic proxRunning, // proximity timer is counting
	output logic irq // event interrupt, level
);
	import intc_pkg::*;

	logic [31:0] reloadValue;
	prio_t triggerLevel;
	logic [31:0] flag;
	logic [31:0] enable;
	prio_t prio [NUM_SRC];
	sub_t sub [NUM_SRC];
	logic [31:0] proxCount;
	logic [EVT_W-1:0] evtStatus;
	logic [EVT_W-1:0] evtEnable;
	logic [31:0] readMux;
	logic mapped;
	logic [2:0] prioWord;
	logic wrDone;
	logic [31:0] next_flag;
	logic [NUM_SRC-1:0] cand;
	logic [NUM_SRC-1:0] trigSrc;
	logic [NUM_SRC-1:0] held;
	logic proxTrigger;
	logic proxExpire;
	logic found;
	logic [SRC_W-1:0] winner;
	prio_t winPrio;
	sub_t winSub;
	logic [EVT_W-1:0] evtSet;

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state so that prdata and pready come from flops

	// a write takes effect only on the completing edge
	// refused addresses are dropped, so an unaligned write never lands in a word
	assign wrDone = psel && penable && pready && pwrite && mapped;

	// word n of the priority bank holds sources 4n to 4n+3, counted from its base
	assign prioWord = 3'((paddr - OFF_PRIO0) >> 2);

	// address decode; anything outside the map answers with pslverr
	always_comb
	begin
		mapped = 1'b1;
		readMux = RST_WORD;
		if (paddr[1:0] != 2'b00)
		begin
			mapped = 1'b0;
		end
		else if (paddr >= OFF_PRIO0 && paddr <= OFF_PRIO_LAST)
		begin
			for (int k = 0; k < SLOTS; k++)
			begin
				// unimplemented gaps between slots stay zero
				readMux[k*SLOT_STRIDE+PRIO_POS +: PRIO_W] =
					prio[{prioWord, 2'(k)}];
				readMux[k*SLOT_STRIDE+SUB_POS +: SUB_W] =
					sub[{prioWord, 2'(k)}];
			end
		end
		else
		begin
			case (paddr)
				OFF_RELOAD: readMux = reloadValue;
				OFF_PROX_CTRL: readMux[PRIO_W-1:0] = triggerLevel;
				OFF_FLAG: readMux = flag;
				OFF_ENABLE: readMux = enable;
				OFF_SELECT:
				begin
					readMux[SEL_SRC_POS +: SRC_W] = reqSource;
					readMux[SEL_PRIO_POS +: PRIO_W] = reqPriority;
					readMux[SEL_SUB_POS +: SUB_W] = reqSubpriority;
					readMux[SEL_VALID_POS] = reqValid;
				end
				OFF_PROX_COUNT: readMux = proxCount;
				OFF_EVT_STATUS: readMux[EVT_W-1:0] = evtStatus;
				OFF_EVT_CLEAR: readMux = RST_WORD; // write-only, reads zero
				OFF_EVT_ENABLE: readMux[EVT_W-1:0] = evtEnable;
				default: mapped = 1'b0;
			endcase
		end
	end

	// pready rises one cycle into the access phase, drops after completion
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RST_WORD;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready && !pwrite)
			begin
				prdata <= mapped ? readMux : RST_WORD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers

	// reload value and proximity trigger level, cleared at reset
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			reloadValue <= RST_WORD;
			triggerLevel <= PRIO_OFF;
		end
		else if (wrDone && paddr == OFF_RELOAD)
		begin
			reloadValue <= pwdata;
		end
		else if (wrDone && paddr == OFF_PROX_CTRL)
		begin
			triggerLevel <= pwdata[PRIO_W-1:0];
		end
	end

	// enable bits are plain read/write
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			enable <= RST_WORD;
		end
		else if (wrDone && paddr == OFF_ENABLE)
		begin
			enable <= pwdata;
		end
	end

	// priority fields: one write updates the four slots of its word
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NUM_SRC; i++)
			begin
				prio[i] <= RST_PRIO;
				sub[i] <= RST_SUB;
			end
		end
		else if (wrDone && paddr >= OFF_PRIO0 && paddr <= OFF_PRIO_LAST)
		begin
			for (int k = 0; k < SLOTS; k++)
			begin
				prio[{prioWord, 2'(k)}] <=
					pwdata[k*SLOT_STRIDE+PRIO_POS +: PRIO_W];
				sub[{prioWord, 2'(k)}] <=
					pwdata[k*SLOT_STRIDE+SUB_POS +: SUB_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request flags: a source request in the same cycle as a software
	// write of zero still sets the flag, so no request is lost
	always_comb
	begin
		next_flag = flag;
		if (wrDone && paddr == OFF_FLAG)
		begin
			next_flag = pwdata;
		end
		next_flag = next_flag | srcReq;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			flag <= RST_WORD;
		end
		else
		begin
			flag <= next_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// proximity timer: a new request at or below the trigger level
	// reloads the count; while it runs, such requests are held back so
	// that bursts of low priority events coalesce into one presentation

	always_comb
	begin
		for (int i = 0; i < NUM_SRC; i++)
		begin
			trigSrc[i] = srcReq[i] && !flag[i] && enable[i] && prio[i] != PRIO_OFF &&
				triggerLevel != PRIO_OFF && prio[i] <= triggerLevel;
			held[i] = proxCount != RST_WORD && prio[i] <= triggerLevel;
			// presentable only when flagged, enabled and not disabled by
			// a zero priority field
			cand[i] = flag[i] && enable[i] && prio[i] != PRIO_OFF &&
				!held[i];
		end
	end

	assign proxTrigger = |trigSrc;
	assign proxExpire = proxCount == 32'h0000_0001 && !proxTrigger;

	// a retrigger while counting restarts from the reload value
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			proxCount <= RST_WORD;
			proxRunning <= 1'b0;
		end
		else
		begin
			if (proxTrigger)
			begin
				proxCount <= reloadValue;
				proxRunning <= reloadValue != RST_WORD;
			end
			else if (proxCount != RST_WORD)
			begin
				proxCount <= proxCount - 32'h0000_0001;
				proxRunning <= proxCount != 32'h0000_0001;
			end
			else
			begin
				proxRunning <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// selection of the request presented to the core

	prio_select u_select
	(
		.cand(cand),
		.prio(prio),
		.sub(sub),
		.found(found),
		.winner(winner),
		.winPrio(winPrio),
		.winSub(winSub)
	);

	// registered so the core sees clean, glitch-free request outputs
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			reqValid <= 1'b0;
			reqSource <= '0;
			reqPriority <= PRIO_OFF;
			reqSubpriority <= RST_SUB;
		end
		else
		begin
			reqValid <= found;
			reqSource <= found ? winner : '0;
			reqPriority <= found ? winPrio : PRIO_OFF;
			reqSubpriority <= found ? winSub : RST_SUB;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event status: sticky bits, write-one-to-clear via the clear register,
	// a set in the same cycle as its clear wins

	assign evtSet[EVT_REQ_POS] = found && !reqValid;
	assign evtSet[EVT_PROX_POS] = proxExpire;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			evtStatus <= RST_EVT;
			evtEnable <= RST_EVT;
		end
		else
		begin
			if (wrDone && paddr == OFF_EVT_CLEAR)
			begin
				evtStatus <= (evtStatus & ~pwdata[EVT_W-1:0]) | evtSet;
			end
			else
			begin
				evtStatus <= evtStatus | evtSet;
			end
			if (wrDone && paddr == OFF_EVT_ENABLE)
			begin
				evtEnable <= pwdata[EVT_W-1:0];
			end
		end
	end

	// interrupt line follows the gated status one cycle later
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(evtStatus & evtEnable);
		end
	end
endmodule : interrupt_flag_enable_priority_bank

// ==== src/intc_pkg.sv ====
// package for the interrupt flag, enable and priority bank
// assumes a 32-bit apb register bus and 32 interrupt sources
package intc_pkg;
	localparam int NUM_SRC = 32;
	localparam int SRC_W = 5;
	localparam int PRIO_W = 3;
	localparam int SUB_W = 2;
	localparam int SLOTS = 4;
	localparam int PRIO_WORDS = 8;
	// byte offsets of the registers
	localparam logic [7:0] OFF_RELOAD = 8'h00;
	localparam logic [7:0] OFF_PROX_CTRL = 8'h04;
	localparam logic [7:0] OFF_FLAG = 8'h08;
	localparam logic [7:0] OFF_ENABLE = 8'h0c;
	localparam logic [7:0] OFF_PRIO0 = 8'h10;
	localparam logic [7:0] OFF_PRIO_LAST = 8'h2c;
	localparam logic [7:0] OFF_SELECT = 8'h30;
	localparam logic [7:0] OFF_PROX_COUNT = 8'h34;
	localparam logic [7:0] OFF_EVT_STATUS = 8'h38;
	localparam logic [7:0] OFF_EVT_CLEAR = 8'h3c;
	localparam logic [7:0] OFF_EVT_ENABLE = 8'h40;
	// field layout of a priority-control word, per slot of 8 bits
	localparam int SLOT_STRIDE = 8;
	localparam int PRIO_POS = 2;
	localparam int SUB_POS = 0;
	// field layout of the selection status word
	localparam int SEL_SRC_POS = 0;
	localparam int SEL_PRIO_POS = 8;
	localparam int SEL_SUB_POS = 12;
	localparam int SEL_VALID_POS = 16;
	// event status bits
	localparam int EVT_REQ_POS = 0;
	localparam int EVT_PROX_POS = 1;
	localparam int EVT_W = 2;
	// values after reset
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [PRIO_W-1:0] RST_PRIO = 3'h0;
	localparam logic [SUB_W-1:0] RST_SUB = 2'h0;
	localparam logic [EVT_W-1:0] RST_EVT = 2'h0;
	localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
	typedef logic [PRIO_W-1:0] prio_t;
	typedef logic [SUB_W-1:0] sub_t;
endpackage : intc_pkg

// ==== src/prio_select.sv ====
// priority resolver: picks one pending source among all candidates
// assumes candidates are already gated by flag, enable and nonzero priority
`timescale 1ns/10ps
module prio_select
(
	input wire logic [intc_pkg::NUM_SRC-1:0] cand, // pending, presentable sources
	input wire intc_pkg::prio_t prio [intc_pkg::NUM_SRC], // priority per source
	input wire intc_pkg::sub_t sub [intc_pkg::NUM_SRC], // subpriority per source
	output logic found, // some candidate exists
	output logic [intc_pkg::SRC_W-1:0] winner, // index of the chosen source
	output intc_pkg::prio_t winPrio, // its priority
	output intc_pkg::sub_t winSub // its subpriority
);
	import intc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// linear scan: strict comparison keeps the lower index on a full tie,
	// a long chain but only 32 deep, fine at 125 MHz with a register after it
	always_comb
	begin
		found = 1'b0;
		winner = '0;
		winPrio = PRIO_OFF;
		winSub = RST_SUB;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (cand[i] && (!found || prio[i] > winPrio ||
				(prio[i] == winPrio && sub[i] > winSub)))
			begin
				found = 1'b1;
				winner = SRC_W'(i);
				winPrio = prio[i];
				winSub = sub[i];
			end
		end
	end
endmodule : prio_select

// ==== verification/intc_bank_properties.sv ====
// checker for the interrupt bank, bound to its top ports
// assumes one clock domain, ref_clk with async resetn
`timescale 1ns/10ps
module intc_bank_properties
(
	input wire logic ref_clk, // clock
	input wire logic resetn, // reset, active low
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // direction
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [intc_pkg::NUM_SRC-1:0] srcReq, // sources
	input wire logic reqValid, // presented
	input wire logic [intc_pkg::SRC_W-1:0] reqSource, // winner
	input wire intc_pkg::prio_t reqPriority, // its priority
	input wire intc_pkg::sub_t reqSubpriority, // its subpriority
	input wire logic proxRunning, // timer counting
	input wire logic irq // event interrupt
);
	import intc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// request side: a presented source is always live, an idle output is all zero
	AST_PRIO_LIVE: assert property (reqValid |-> reqPriority != PRIO_OFF)
		else $error("presented source has priority zero");
	AST_IDLE_ZERO: assert property (!reqValid |->
		{reqSource, reqPriority, reqSubpriority} == 10'h0)
		else $error("idle request outputs not zero");
	// bus side: exactly one wait state, then a single ready pulse
	AST_WAIT_ONE: assert property (psel && penable && !pready |=> pready)
		else $error("ready not one cycle after access");
	AST_READY_ONCE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_ERR_ALIGN: assert property (psel && penable && !pready &&
		paddr[1:0] != 2'h0 |=> pslverr)
		else $error("unaligned access not refused");
	// read data only reloads on reads, a refused read returns all zero
	AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	// unimplemented bits of priority words and of the trigger level read zero
	AST_PRIO_GAPS: assert property (pready && !pwrite && paddr >= OFF_PRIO0 &&
		paddr <= OFF_PRIO_LAST |-> (prdata & 32'he0e0e0e0) == 32'h0)
		else $error("priority word gap bits not zero");
	AST_LEVEL_GAPS: assert property (pready && !pwrite && paddr == OFF_PROX_CTRL
		|-> prdata[31:3] == 29'h0)
		else $error("trigger level upper bits not zero");
	COV_REQ: cover property (reqValid);
	COV_PROX: cover property (proxRunning);
	COV_IRQ: cover property (irq);
endmodule : intc_bank_properties
bind interrupt_flag_enable_priority_bank intc_bank_properties i_intc_bank_properties
(
	.ref_clk(ref_clk),
	.resetn(resetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.srcReq(srcReq),
	.reqValid(reqValid),
	.reqSource(reqSource),
	.reqPriority(reqPriority),
	.reqSubpriority(reqSubpriority),
	.proxRunning(proxRunning),
	.irq(irq)
);

// ==== verification/core_model.sv ====
// core model: takes the presented request after a settable lag
// assumes registered request outputs on ref_clk
`timescale 1ns/10ps
module core_model
(
	input wire logic ref_clk, // clock
	input wire logic resetn, // reset, active low
	input wire logic reqValid, // request presented
	input wire logic [intc_pkg::SRC_W-1:0] reqSource, // presented source
	input wire logic [1:0] lag, // cycles before taking
	output logic [intc_pkg::SRC_W-1:0] takenSrc // last source taken
);
	import intc_pkg::*;
	logic [1:0] waited;
	// a slow core only takes a request that stayed up for lag cycles
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			waited <= 2'h0;
			takenSrc <= 5'h0;
		end
		else if (!reqValid)
			waited <= 2'h0;
		else if (waited != lag)
			waited <= waited + 2'h1;
		else
			takenSrc <= reqSource;
	end
endmodule : core_model

// ==== verification/interrupt_flag_enable_priority_bank_tb_top.sv ====
// bench for the interrupt bank: apb access, random priority sweep, proximity, events
// assumes the checker binds itself and the core model watches the request outputs
`timescale 1ns/10ps
module interrupt_flag_enable_priority_bank_tb_top;
	import intc_pkg::*;
	logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, srcReq = 32'h0, prdata, rd, v, en, pw [8];
	logic pready, pslverr, reqValid, proxRunning, irq, err;
	logic [4:0] reqSource, takenSrc;
	prio_t reqPriority;
	sub_t reqSubpriority;
	logic [1:0] lag = 2'h0;
	logic [10:0] exp;
	int failCount = 0, comparisons = 0;
	always #4 ref_clk = ~ref_clk;
	interrupt_flag_enable_priority_bank i_interrupt_flag_enable_priority_bank
	(
		.ref_clk(ref_clk),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.srcReq(srcReq),
		.reqValid(reqValid),
		.reqSource(reqSource),
		.reqPriority(reqPriority),
		.reqSubpriority(reqSubpriority),
		.proxRunning(proxRunning),
		.irq(irq)
	);
	core_model i_core_model
	(
		.ref_clk(ref_clk),
		.resetn(resetn),
		.reqValid(reqValid),
		.reqSource(reqSource),
		.lag(lag),
		.takenSrc(takenSrc)
	);
	////////////////////////////////////////
	// one apb transfer; setup, access, then wait for ready with no assumed
	// cycle count, only the watchdog ends a hung wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			failCount++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// expected winner: highest priority, then subpriority, ties to lowest index
	// result is {valid, source, priority, subpriority}, all zero when none
	function automatic logic [10:0] best(input logic [31:0] p);
		logic [4:0] bk;
		logic [7:0] s;
		best = 11'h0;
		bk = 5'h0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			s = pw[i / 4][8 * (i % 4) +: 8];
			if (p[i] && s[4:2] != PRIO_OFF && s[4:0] > bk)
			begin
				bk = s[4:0];
				best = {1'b1, 5'(i), s[4:0]};
			end
		end
	endfunction : best
	task automatic completeRun;
		$display("comparisons %0d failCount %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : completeRun
	// watchdog well beyond the few hundred cycles the tests take
	initial
	begin
		#400000;
		failCount++;
		$display("[ERR] %0t watchdog expired", $time);
		completeRun();
	end
	////////////////////////////////////////
	initial
	begin
		void'($urandom(95009));
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int a = 0; a <= 'h2c; a += 4)
		begin
			apb(1'b0, 8'(a), 32'h0);
			chk(rd, 32'h0);
		end
		v = $urandom();
		apb(1'b1, OFF_RELOAD, v);
		apb(1'b0, OFF_RELOAD, 32'h0);
		chk(rd, v);
		// random words incl. gap bits; only field bits may come back
		foreach (pw[k])
		begin
			v = $urandom();
			pw[k] = v & 32'h1f1f1f1f;
			apb(1'b1, OFF_PRIO0 + 8'(4 * k), v);
			apb(1'b0, OFF_PRIO0 + 8'(4 * k), 32'h0);
			chk(rd, pw[k]);
		end
		en = $urandom();
		apb(1'b1, OFF_ENABLE, en);
		apb(1'b0, OFF_ENABLE, 32'h0);
		chk(rd, en);
		apb(1'b1, OFF_FLAG, v);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk(rd, v);
		apb(1'b1, OFF_FLAG, 32'h0);
		// random source sets, first none, then all, against the expected winner
		for (int t = 0; t < 12; t++)
		begin
			v = (t == 0) ? 32'h0 : (t == 1) ? 32'hffffffff : $urandom() & $urandom();
			@(posedge ref_clk);
			srcReq <= v;
			lag <= 2'($urandom());
			@(posedge ref_clk);
			srcReq <= 32'h0;
			repeat (6) @(posedge ref_clk);
			exp = best(v & en);
			rd = {21'h0, reqValid, reqSource, reqPriority, reqSubpriority};
			chk(rd, {21'h0, exp});
			if (exp[10])
				chk({27'h0, takenSrc}, {27'h0, exp[9:5]});
			apb(1'b1, OFF_FLAG, 32'h0);
		end
		apb(1'b0, 8'h80, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		// proximity hold of a level-1 source, then the events it raises
		apb(1'b1, OFF_PRIO0, 32'h4);
		apb(1'b1, OFF_ENABLE, 32'h1);
		apb(1'b1, OFF_RELOAD, 32'h5);
		apb(1'b1, OFF_PROX_CTRL, 32'h7);
		apb(1'b1, OFF_EVT_CLEAR, 32'h3);
		apb(1'b1, OFF_EVT_ENABLE, 32'h3);
		@(posedge ref_clk);
		srcReq <= 32'h1;
		@(posedge ref_clk);
		srcReq <= 32'h0;
		repeat (4) @(posedge ref_clk);
		chk({30'h0, proxRunning, reqValid}, 32'h2);
		repeat (10) @(posedge ref_clk);
		chk({30'h0, proxRunning, reqValid}, 32'h1);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, OFF_SELECT, 32'h0);
		chk(rd, 32'h00010100);
		apb(1'b0, OFF_EVT_STATUS, 32'h0);
		chk({rd[30:0], irq}, 32'h7);
		apb(1'b1, OFF_EVT_CLEAR, 32'h3);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		// level 1 with a priority 2 source: above the level, so no hold
		apb(1'b1, OFF_FLAG, 32'h0);
		apb(1'b1, OFF_PROX_CTRL, 32'h1);
		apb(1'b1, OFF_PRIO0, 32'h8);
		@(posedge ref_clk);
		srcReq <= 32'h1;
		@(posedge ref_clk);
		srcReq <= 32'h0;
		repeat (2) @(posedge ref_clk);
		chk({30'h0, proxRunning, reqValid}, 32'h1);
		completeRun();
	end
endmodule : interrupt_flag_enable_priority_bank_tb_top
